// file: hdl/bbcfg_pkg.sv
// Package of register offsets, field positions and codes for the channel config bank.
package bbcfg_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned NUM_CH = 2;
	localparam logic [7:0] CH1_CTRL_ADDR = 8'h2c;
	localparam logic [7:0] CH2_TV_ADDR = 8'h2d;
	localparam logic [7:0] CH2_CTRL_ADDR = 8'h2e;
	localparam int unsigned RESERVED_BIT_BIT = 7;
	localparam int unsigned TOPO_BIT = 6;
	localparam int unsigned ILIM_HI = 5;
	localparam int unsigned ILIM_LO = 4;
	localparam int unsigned DIS_BIT = 3;
	localparam int unsigned EN_HI = 2;
	localparam int unsigned EN_LO = 0;
	localparam int unsigned TV_HI = 6;
	localparam int unsigned TV_W = 7;
	localparam logic RESERVED_BIT_RESET = 1'b0;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam logic [6:0] TV_MAX_CODE = 7'h5e;
	localparam int unsigned TV_BASE_MV = 800;
	localparam int unsigned TV_STEP_MV = 50;
	localparam logic [15:0] ILIM_MA [4] = '{16'h03e8, 16'h02ee, 16'h01f4,
		16'h014d};
	typedef enum logic [2:0] {
		BBCFG_EN_SLOT0 = 3'b000,
		BBCFG_EN_SLOT1 = 3'b001,
		BBCFG_EN_SLOT2 = 3'b010,
		BBCFG_EN_SLOT3 = 3'b011,
		BBCFG_EN_OFF_A = 3'b100,
		BBCFG_EN_OFF_B = 3'b101,
		BBCFG_EN_ON_A = 3'b110,
		BBCFG_EN_ON_B = 3'b111
	} bbcfg_en_t;
	localparam int unsigned EN_FORCE_BIT = 2;
	localparam int unsigned EN_ON_BIT = 1;
endpackage

// file: hdl/bbcfg_ch_if.sv
// Interface carrying one channel's control fields to its decode module.
`timescale 1ns/1ps
`default_nettype none
interface bbcfg_ch_if;
	logic [7:0] ctrl;
	logic [3:0] seq_slot_active;
	logic enabled;
	logic buck_only;
	logic [15:0] ilim_ma;
	logic discharge;
	modport src (output ctrl, output seq_slot_active, input enabled,
		input buck_only, input ilim_ma, input discharge);
	modport dec (input ctrl, input seq_slot_active, output enabled,
		output buck_only, output ilim_ma, output discharge);
endinterface
`default_nettype wire

// file: hdl/bbcfg_ch_decode.sv
// Decoder turning one channel control byte into regulator controls.
`timescale 1ns/1ps
`default_nettype none
module bbcfg_ch_decode (
	bbcfg_ch_if.dec ch
);
	logic [2:0] en_code;
	always_comb
	begin
		en_code = ch.ctrl[bbcfg_pkg::EN_HI:bbcfg_pkg::EN_LO];
		ch.buck_only = ch.ctrl[bbcfg_pkg::TOPO_BIT];
		ch.ilim_ma = bbcfg_pkg::ILIM_MA[
			ch.ctrl[bbcfg_pkg::ILIM_HI:bbcfg_pkg::ILIM_LO]];
		if (en_code[bbcfg_pkg::EN_FORCE_BIT])
			ch.enabled = en_code[bbcfg_pkg::EN_ON_BIT];
		else
			ch.enabled = ch.seq_slot_active[en_code[1:0]];
		ch.discharge = ch.ctrl[bbcfg_pkg::DIS_BIT] & ~ch.enabled;
	end
endmodule
`default_nettype wire

// file: hdl/bbcfg_regs.sv
// Register bank for two buck-boost channels: control for both, target voltage for channel 2 only.
//
// Contract
// - Bits 5:4 set the peak limit 1.000A, 0.750A, 0.500A or 0.333A.
// - With bit 3 set, a disabled channel's output is discharged to ground.
// - Enable codes 000 to 011 follow sequencer slots 0 to 3.
// - Enable codes 100/101 force off and 110/111 force on.
// - Channel 2 voltage is 0.8V plus 50mV per code, 5.5V at 0x5e.
// - Channel 2 control has the same fields and encodings as channel 1.
`timescale 1ns/1ps
`default_nettype none
module bbcfg_regs #(
	parameter int unsigned NUM_CH = bbcfg_pkg::NUM_CH,
	parameter int unsigned ILIM_W = 16
) (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic wr_en_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out,
	input wire logic [6:0] otp_ch1_ctrl_in,
	input wire logic [6:0] otp_ch2_ctrl_in,
	input wire logic [6:0] otp_ch2_tv_in,
	input wire logic [3:0] seq_slot_active_in,
	output logic [1:0] ch_enabled_out,
	output logic [1:0] ch_buck_only_out,
	output logic [1:0] ch_discharge_out,
	output logic [31:0] ch_ilim_ma_out,
	output logic [6:0] ch2_tv_code_out,
	output logic [15:0] ch2_tv_mv_out
);
	// ****************************************
	// Register state.
	// ****************************************
	logic [7:0] ctrl_reg [NUM_CH];
	logic [7:0] ctrl_next [NUM_CH];
	logic [6:0] tv_reg;
	logic [6:0] tv_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [6:0] otp_ctrl [NUM_CH];

	// The port widths serve exactly two channels with 16-bit limits.
	generate
		if (NUM_CH != 2 || ILIM_W != 16)
		begin : g_bad_param
			$error("bbcfg_regs needs NUM_CH of 2 and ILIM_W of 16.");
		end
	endgenerate

	assign otp_ctrl[0] = otp_ch1_ctrl_in;
	assign otp_ctrl[1] = otp_ch2_ctrl_in;

	always_comb
	begin
		ctrl_next = ctrl_reg;
		tv_next = tv_reg;
		rdata_next = rdata_reg;
		if (wr_en_in)
		begin
			if (addr_in == bbcfg_pkg::CH1_CTRL_ADDR)
				ctrl_next[0] = wdata_in;
			if (addr_in == bbcfg_pkg::CH2_CTRL_ADDR)
				ctrl_next[1] = wdata_in;
			if (addr_in == bbcfg_pkg::CH2_TV_ADDR)
				tv_next = wdata_in[bbcfg_pkg::TV_HI:0];
		end
		unique case (addr_in)
			bbcfg_pkg::CH1_CTRL_ADDR: rdata_next = ctrl_reg[0];
			bbcfg_pkg::CH2_TV_ADDR: rdata_next = {1'b0, tv_reg};
			bbcfg_pkg::CH2_CTRL_ADDR: rdata_next = ctrl_reg[1];
			default: rdata_next = bbcfg_pkg::READ_ZERO;
		endcase
	end

	// Factory options are sampled by the clocked reset, not an async load.
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			for (int i = 0; i < NUM_CH; i++)
				ctrl_reg[i] <= {bbcfg_pkg::RESERVED_BIT_RESET, otp_ctrl[i]};
			tv_reg <= otp_ch2_tv_in;
			rdata_reg <= bbcfg_pkg::READ_ZERO;
		end
		else if (ce_in)
		begin
			ctrl_reg <= ctrl_next;
			tv_reg <= tv_next;
			rdata_reg <= rdata_next;
		end
	end

	assign rdata_out = rdata_reg;

	// ****************************************
	// Per-channel decode.
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_ch
			bbcfg_ch_if chif ();
			assign chif.ctrl = ctrl_reg[g];
			assign chif.seq_slot_active = seq_slot_active_in;
			bbcfg_ch_decode u_dec (
				.ch(chif.dec)
			);
			assign ch_enabled_out[g] = chif.enabled;
			assign ch_buck_only_out[g] = chif.buck_only;
			assign ch_discharge_out[g] = chif.discharge;
			assign ch_ilim_ma_out[g*ILIM_W +: ILIM_W] = chif.ilim_ma;
		end
	endgenerate

	assign ch2_tv_code_out = tv_reg;
	// Millivolt view of the target code.
	assign ch2_tv_mv_out = 16'(bbcfg_pkg::TV_BASE_MV
		+ bbcfg_pkg::TV_STEP_MV * tv_reg);
endmodule
`default_nettype wire

// file: tb/bbcfg_properties.sv
// Port assertions for the channel config bank.
`timescale 1ns/1ps
`default_nettype none
module bbcfg_chk (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic wr_en_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic [7:0] rdata_out,
	input wire logic [6:0] otp_ch2_tv_in,
	input wire logic [1:0] ch_enabled_out,
	input wire logic [1:0] ch_buck_only_out,
	input wire logic [1:0] ch_discharge_out,
	input wire logic [31:0] ch_ilim_ma_out,
	input wire logic [6:0] ch2_tv_code_out,
	input wire logic [15:0] ch2_tv_mv_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);
	sequence s_w1;
		ce_in && wr_en_in && addr_in == 8'h2c;
	endsequence
	sequence s_w2;
		ce_in && wr_en_in && addr_in == 8'h2e;
	endsequence
	sequence s_rd_tv;
		ce_in && !wr_en_in && addr_in == 8'h2d;
	endsequence
	property p_mv;
		ch2_tv_mv_out == 16'h0320 + 16'h0032 * ch2_tv_code_out;
	endproperty
	a_mv: assert property (p_mv) else $error("mv");
	property p_en;
		s_w1 ##0 wdata_in[2] |=> ch_enabled_out[0] == $past(wdata_in[1]);
	endproperty
	a_en: assert property (p_en) else $error("en");
	property p_rd;
		s_rd_tv |=> rdata_out == {1'b0, ch2_tv_code_out};
	endproperty
	a_rd: assert property (p_rd) else $error("rd");
	property p_ch2;
		s_w2 |=> ch_buck_only_out[1] == $past(wdata_in[6]);
	endproperty
	a_ch2: assert property (p_ch2) else $error("ch2 mode");
	property p_ilim;
		s_w2 ##0 wdata_in[5:4] == 2'b11 |=> ch_ilim_ma_out[31:16] == 16'h014d;
	endproperty
	a_ilim: assert property (p_ilim) else $error("ilim");
	property p_dis;
		ch_discharge_out[0] |-> !ch_enabled_out[0];
	endproperty
	a_dis: assert property (p_dis) else $error("dis");
	property p_ce;
		!ce_in |=> $stable(ch2_tv_code_out) && $stable(rdata_out);
	endproperty
	a_ce: assert property (p_ce) else $error("ce freeze");
	property p_rst;
		disable iff (1'b0)
		srst_in |=> ch2_tv_code_out == $past(otp_ch2_tv_in);
	endproperty
	a_rst: assert property (p_rst) else $error("rst tv");
endmodule
bind bbcfg_regs bbcfg_chk u_chk (
	.clk_sys_in(clk_sys_in),
	.srst_in(srst_in),
	.ce_in(ce_in),
	.wr_en_in(wr_en_in),
	.addr_in(addr_in),
	.wdata_in(wdata_in),
	.rdata_out(rdata_out),
	.otp_ch2_tv_in(otp_ch2_tv_in),
	.ch_enabled_out(ch_enabled_out),
	.ch_buck_only_out(ch_buck_only_out),
	.ch_discharge_out(ch_discharge_out),
	.ch_ilim_ma_out(ch_ilim_ma_out),
	.ch2_tv_code_out(ch2_tv_code_out),
	.ch2_tv_mv_out(ch2_tv_mv_out)
);
`default_nettype wire

// file: tb/bbcfg_regs_tb.sv
// Self-checking bench for the channel config bank.
`timescale 1ns/1ps
`default_nettype none
module bbcfg_regs_tb;
	logic clk_sys_in = 1'b0, srst_in = 1'b1, ce_in = 1'b1, wr_en_in = 1'b0, en;
	logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
	logic [6:0] otp_ch1_ctrl_in = 7'h5a, otp_ch2_ctrl_in = 7'h27;
	logic [6:0] otp_ch2_tv_in = 7'h14, ch2_tv_code_out;
	logic [3:0] seq_slot_active_in = 4'h0;
	logic [1:0] ch_enabled_out, ch_buck_only_out, ch_discharge_out;
	logic [31:0] ch_ilim_ma_out;
	logic [15:0] ch2_tv_mv_out;
	logic [15:0] lim [4] = '{16'h03e8, 16'h02ee, 16'h01f4, 16'h014d};
	int n_errors = 0, total_checks = 0, done = 0;
	bbcfg_regs u_dut (
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.wr_en_in(wr_en_in),
		.addr_in(addr_in),
		.wdata_in(wdata_in),
		.rdata_out(rdata_out),
		.otp_ch1_ctrl_in(otp_ch1_ctrl_in),
		.otp_ch2_ctrl_in(otp_ch2_ctrl_in),
		.otp_ch2_tv_in(otp_ch2_tv_in),
		.seq_slot_active_in(seq_slot_active_in),
		.ch_enabled_out(ch_enabled_out),
		.ch_buck_only_out(ch_buck_only_out),
		.ch_discharge_out(ch_discharge_out),
		.ch_ilim_ma_out(ch_ilim_ma_out),
		.ch2_tv_code_out(ch2_tv_code_out),
		.ch2_tv_mv_out(ch2_tv_mv_out)
	);
	always #2 clk_sys_in = ~clk_sys_in;
	task go; @(posedge clk_sys_in) #1; endtask
	task chk(input string nm, input logic [31:0] s, e);
		total_checks++;
		n_errors += (s !== e);
		if (s !== e) $display("BAD %s exp %h got %h", nm, e, s);
	endtask
	task acc(input logic [7:0] a, dat, input logic w);
		go;
		addr_in = a;
		wdata_in = dat;
		wr_en_in = w;
		go;
		wr_en_in = 1'b0;
	endtask
	task t_ctrl;
		for (int k = 0; k < 16; k++)
		begin
			seq_slot_active_in = 4'h3 << k[0];
			acc(k[3] ? 8'h2e : 8'h2c,
				{1'b0, k[1], k[1:0], !k[0], k[2:0]}, 1'b1);
			en = k[2] ? k[1] : seq_slot_active_in[k[1:0]];
			chk("en", ch_enabled_out[k[3]], en);
			chk("mode", ch_buck_only_out[k[3]], k[1]);
			chk("dis", ch_discharge_out[k[3]], !k[0] && !en);
			chk("ilim", ch_ilim_ma_out[k[3]*16 +: 16], lim[k[1:0]]);
		end
		$display("done t_ctrl");
	endtask
	task t_tv;
		acc(8'h2d, 8'hde, 1'b1);
		chk("mv", ch2_tv_mv_out, 16'h157c);
		acc(8'h2d, 8'h00, 1'b0);
		chk("rd", rdata_out, 8'h5e);
		$display("done t_tv");
	endtask
	task t_rd;
		acc(8'h2c, 8'h15, 1'b1);
		acc(8'h2e, 8'h6a, 1'b1);
		acc(8'h2f, 8'hff, 1'b1);
		acc(8'h2c, 8'h00, 1'b0);
		chk("rd1", rdata_out, 8'h15);
		acc(8'h2e, 8'h00, 1'b0);
		chk("rd2", rdata_out, 8'h6a);
		acc(8'h30, 8'h00, 1'b0);
		chk("rdx", rdata_out, 8'h00);
		$display("done t_rd");
	endtask
	task t_ce;
		ce_in = 1'b0;
		acc(8'h2d, 8'h01, 1'b1);
		ce_in = 1'b1;
		chk("ce tv", ch2_tv_code_out, 7'h5e);
		chk("ce rd", rdata_out, 8'h5e);
		$display("done t_ce");
	endtask
	task t_rst;
		srst_in = 1'b1;
		go;
		srst_in = 1'b0;
		chk("tv", ch2_tv_code_out, 7'h14);
		chk("mv0", ch2_tv_mv_out, 16'h0708);
		acc(8'h2c, 8'h00, 1'b0);
		chk("rst1", rdata_out, 8'h5a);
		acc(8'h2e, 8'h00, 1'b0);
		chk("rst2", rdata_out, 8'h27);
		done = 1;
		$display("done t_rst");
	endtask
	task report_and_stop;
		n_errors += !done;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (5) go;
		srst_in = 1'b0;
		t_ctrl;
		t_rd;
		t_tv;
		t_ce;
		t_rst;
		report_and_stop;
	end
	initial #4000 report_and_stop;
endmodule
`default_nettype wire
